// ===== hdl/ccp_pwm.sv
// Purpose: Standard PWM mode of a capture/compare/PWM unit, AXI4-Lite registers
// Assumes: aclk is the oscillator clock; sleep comes from logic on aclk
// Notes: Timer lives in ccp_tmr
// What this block does
// - Period is (period register + 1) x 4 oscillator cycles x prescale.
// - After count matches period: clear count, set pin unless duty 0, latch duty.
// - Postscaler never changes the PWM period or frequency.
// - 10-bit duty comes from the byte pair, placed by the alignment bit.
// - Duty bytes writable anytime; used only after next period match.
// - Time base is count plus two prescaler or clock phase bits.
// - Pin goes low when the time base equals the buffered duty.
// - Duty beyond the period leaves the pin unchanged that period.
// - Resolution is log2(4 x (period + 1)) bits, ten at 255.
// - Duty ratio is duty / (4 x (period + 1)).
// - Sleep freezes timer and state and holds the pin level.
// - Reset returns registers to reset values and the pin to input.
// - Each unit picks its timer through a 2-bit select field.
// - Alignment 0 right-justifies the duty, alignment 1 left-justifies it.
// - Writing zero to unit control forces the output latch low.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_cfg.svh"
module ccp_pwm #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sleep,
  output logic pwm_output_pin,
  output logic pwm_pin_oe,
  output logic irq
);
  ccp_tmr_if tmr ();

  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  ccp_pkg::ccp_rd_state_t rd_state_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_next;

  logic [7:0] ctl_reg;
  logic [7:0] cap_reg;
  logic [7:0] dlo_reg;
  logic [7:0] dhi_reg;
  logic [7:0] tsel_reg;
  logic [7:0] tper_reg;
  logic [7:0] tcon_reg;
  logic [7:0] tclk_reg;
  logic [7:0] ie_reg;
  logic [7:0] if_reg;
  logic [7:0] pmd_reg;
  logic [7:0] pdir_reg;
  logic out_reg;
  ccp_pkg::ccp_duty_t duty_buf_reg;

  logic wr_fire;
  logic wr_en;
  logic rd_fire;
  logic ctl_zero_wr;
  logic pwm_run;
  logic [7:0] if_set;
  logic [7:0] if_clr;
  ccp_pkg::ccp_duty_t duty_val;
  ccp_pkg::ccp_duty_t time_base;
  logic [10:0] tb_ahead;
  logic duty_hit;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= `CCP_A_PDIR) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = wr_en && (a == b);
  endfunction : hit

  // ==========================================
  // AXI4-Lite write channel
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_en = wr_fire && w_lane0_reg && addr_ok(aw_addr_reg);
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= 8'(awaddr);
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata[7:0];
      w_lane0_reg <= wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `CCP_RESP_OK;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_ok(aw_addr_reg) ? `CCP_RESP_OK : `CCP_RESP_ERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  assign arready = (rd_state_reg == ccp_pkg::CCP_RD_IDLE);
  assign rd_fire = arvalid && arready;
  assign rvalid = (rd_state_reg == ccp_pkg::CCP_RD_RESP);
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_comb begin
    rd_next = 8'h00;
    if (araddr == `CCP_A_CTL) begin
      rd_next = {ctl_reg[7], 1'b0, out_reg, ctl_reg[4:0]};
    end else if (araddr == `CCP_A_CAP) begin
      rd_next = cap_reg;
    end else if (araddr == `CCP_A_DLO) begin
      rd_next = dlo_reg;
    end else if (araddr == `CCP_A_DHI) begin
      rd_next = dhi_reg;
    end else if (araddr == `CCP_A_TSEL) begin
      rd_next = tsel_reg;
    end else if (araddr == `CCP_A_TCNT) begin
      rd_next = tmr.count;
    end else if (araddr == `CCP_A_TPER) begin
      rd_next = tper_reg;
    end else if (araddr == `CCP_A_TCON) begin
      rd_next = tcon_reg;
    end else if (araddr == `CCP_A_TCLK) begin
      rd_next = tclk_reg;
    end else if (araddr == `CCP_A_IE) begin
      rd_next = ie_reg;
    end else if (araddr == `CCP_A_IF) begin
      rd_next = if_reg;
    end else if (araddr == `CCP_A_PMD) begin
      rd_next = pmd_reg;
    end else if (araddr == `CCP_A_PDIR) begin
      rd_next = pdir_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= ccp_pkg::CCP_RD_IDLE;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `CCP_RESP_OK;
    end else begin
      case (rd_state_reg)
        ccp_pkg::CCP_RD_IDLE: begin
          if (arvalid) begin
            rd_state_reg <= ccp_pkg::CCP_RD_RESP;
            rdata_reg <= {24'h00_0000, rd_next};
            rresp_reg <= addr_ok(8'(araddr)) ? `CCP_RESP_OK : `CCP_RESP_ERR;
          end
        end
        default: begin
          if (rready) begin
            rd_state_reg <= ccp_pkg::CCP_RD_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Configuration registers
  assign ctl_zero_wr = hit(aw_addr_reg, `CCP_A_CTL) && (w_data_reg == 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= `CCP_RST_ZERO;
      cap_reg <= `CCP_RST_ZERO;
      tsel_reg <= `CCP_TSEL_RST;
      tper_reg <= `CCP_TPER_RST;
      tcon_reg <= `CCP_RST_ZERO;
      tclk_reg <= `CCP_RST_ZERO;
      ie_reg <= `CCP_RST_ZERO;
      pmd_reg <= `CCP_RST_ZERO;
      pdir_reg <= `CCP_PDIR_RST;
    end else if (hit(aw_addr_reg, `CCP_A_CTL)) begin
      ctl_reg <= w_data_reg & `CCP_CTL_WMASK;
    end else if (hit(aw_addr_reg, `CCP_A_CAP)) begin
      cap_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_TSEL)) begin
      tsel_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_TPER)) begin
      tper_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_TCON)) begin
      tcon_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_TCLK)) begin
      tclk_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_IE)) begin
      ie_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_PMD)) begin
      pmd_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_PDIR)) begin
      pdir_reg <= w_data_reg;
    end
  end

  // Duty bytes take writes at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dlo_reg <= `CCP_RST_ZERO;
      dhi_reg <= `CCP_RST_ZERO;
    end else if (hit(aw_addr_reg, `CCP_A_DLO)) begin
      dlo_reg <= w_data_reg;
    end else if (hit(aw_addr_reg, `CCP_A_DHI)) begin
      dhi_reg <= w_data_reg;
    end
  end

  // ==========================================
  // Period timer
  assign tmr.on = tcon_reg[`CCP_TCON_ON] && (tclk_reg[3:0] == `CCP_CS_FOSC4);
  assign tmr.sleep = sleep;
  assign tmr.cnt_wr = hit(aw_addr_reg, `CCP_A_TCNT);
  assign tmr.cnt_wdata = w_data_reg;
  assign tmr.period = tper_reg;
  assign tmr.ps = tcon_reg[6:4];
  assign tmr.outps = tcon_reg[3:0];

  ccp_tmr u_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(tmr)
  );

  // ==========================================
  // PWM core
  assign duty_val = ctl_reg[`CCP_CTL_FMT] ? {dhi_reg, dlo_reg[7:6]} : {dhi_reg[1:0], dlo_reg};
  assign time_base = {tmr.count, tmr.tb_lo};
  // Clear on the edge at which the time base reaches the duty value
  assign tb_ahead = {1'b0, time_base} + 11'h001;
  assign duty_hit = tmr.tb_step && (tb_ahead == {1'b0, duty_buf_reg});
  assign pwm_run = ctl_reg[`CCP_CTL_EN] && (ctl_reg[3:2] == `CCP_MODE_PWM)
                   && (tsel_reg[1:0] == `CCP_TSEL_OWN) && !pmd_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_buf_reg <= 10'h000;
    end else if (tmr.wrap) begin
      duty_buf_reg <= duty_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ctl_zero_wr) begin
      out_reg <= 1'b0;
    end else if (sleep) begin
      out_reg <= out_reg;
    end else if (!pwm_run) begin
      out_reg <= 1'b0;
    end else if (tmr.wrap) begin
      out_reg <= (duty_val != 10'h000);
    end else if (duty_hit) begin
      out_reg <= 1'b0;
    end
  end

  assign pwm_output_pin = out_reg;
  assign pwm_pin_oe = !pdir_reg[0];

  // ==========================================
  // Interrupt status
  assign if_set = {6'h00, tmr.wrap && pwm_run, tmr.post_hit};
  assign if_clr = (rd_fire && (araddr == `CCP_A_IF)) ? 8'hFF : 8'h00;
  assign irq = |(if_reg & ie_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if_reg <= `CCP_RST_ZERO;
    end else begin
      if_reg <= (if_reg & ~if_clr) | if_set;
    end
  end

  // ==========================================
  // Checks
  property p_set_on_wrap;
    @(posedge aclk) disable iff (!aresetn)
      (tmr.wrap && pwm_run && !sleep && !ctl_zero_wr && duty_val != 10'h000) |=> out_reg;
  endproperty
  a_set_on_wrap: assert property (p_set_on_wrap) else $error("pin not set at period start");

  property p_zero_duty;
    @(posedge aclk) disable iff (!aresetn) (tmr.wrap && duty_val == 10'h000) |=> !out_reg;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin set with zero duty");

  property p_clear_on_match;
    @(posedge aclk) disable iff (!aresetn)
      (!tmr.wrap && duty_hit) |=> !out_reg;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("pin not cleared at duty match");

  property p_duty_hold;
    @(posedge aclk) disable iff (!aresetn) !tmr.wrap |=> $stable(duty_buf_reg);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty buffer changed off match");

  property p_ctl_zero;
    @(posedge aclk) disable iff (!aresetn) ctl_zero_wr |=> !out_reg ##1 !pwm_run;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("output latch not forced low");

  property p_full_duty;
    @(posedge aclk) disable iff (!aresetn)
      (out_reg && pwm_run && !tmr.wrap && !ctl_zero_wr && duty_buf_reg > {tper_reg, 2'h3})
      |=> out_reg;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("pin dropped with duty beyond period");

  property p_sleep_pin;
    @(posedge aclk) disable iff (!aresetn) (sleep && !ctl_zero_wr) |=> $stable(out_reg);
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("pin changed in sleep");

  property p_reset_pin;
    @(posedge aclk) $rose(aresetn) |-> !pwm_pin_oe && !out_reg && !irq;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("pin not input after reset");
endmodule : ccp_pwm
`default_nettype wire

// ===== common/ccp_cfg.svh
// Purpose: Offsets, field positions and reset values of the PWM unit
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH
// ==========================================
// Register byte offsets
`define CCP_A_CTL 8'h00
`define CCP_A_CAP 8'h04
`define CCP_A_DLO 8'h08
`define CCP_A_DHI 8'h0C
`define CCP_A_TSEL 8'h10
`define CCP_A_TCNT 8'h14
`define CCP_A_TPER 8'h18
`define CCP_A_TCON 8'h1C
`define CCP_A_TCLK 8'h20
`define CCP_A_IE 8'h24
`define CCP_A_IF 8'h28
`define CCP_A_PMD 8'h2C
`define CCP_A_PDIR 8'h30
// ==========================================
// Field positions and codes
`define CCP_CTL_EN 7
`define CCP_CTL_OUT 5
`define CCP_CTL_FMT 4
`define CCP_CTL_WMASK 8'h9F
`define CCP_MODE_PWM 2'h3
`define CCP_TCON_ON 7
`define CCP_TSEL_OWN 2'h1
`define CCP_CS_FOSC4 4'h1
`define CCP_IF_TMR 0
`define CCP_IF_PER 1
`define CCP_RESP_OK 2'h0
`define CCP_RESP_ERR 2'h2
// ==========================================
// Reset values
`define CCP_RST_ZERO 8'h00
`define CCP_TSEL_RST 8'h55
`define CCP_TPER_RST 8'hFF
`define CCP_PDIR_RST 8'h01
`endif

// ===== common/ccp_pkg.sv
// Purpose: Shared types of the PWM unit
// Assumes: Nothing
// Notes: Constants live in ccp_cfg.svh
`default_nettype none
package ccp_pkg;
  typedef logic [9:0] ccp_duty_t;
  typedef enum logic [0:0] {CCP_RD_IDLE, CCP_RD_RESP} ccp_rd_state_t;
endpackage : ccp_pkg
`default_nettype wire

// ===== common/ccp_tmr_if.sv
// Purpose: Link between the PWM unit and its period timer
// Assumes: One clock domain
// Notes: Control flows in, count and events flow out
`timescale 1ns/1ns
`default_nettype none
interface ccp_tmr_if;
  logic on;
  logic sleep;
  logic cnt_wr;
  logic [7:0] cnt_wdata;
  logic [7:0] period;
  logic [2:0] ps;
  logic [3:0] outps;
  logic [7:0] count;
  logic [1:0] tb_lo;
  logic wrap;
  logic post_hit;
  logic tb_step;
  modport unit (output on, sleep, cnt_wr, cnt_wdata, period, ps, outps,
                input count, tb_lo, wrap, post_hit, tb_step);
  modport tmr (input on, sleep, cnt_wr, cnt_wdata, period, ps, outps,
               output count, tb_lo, wrap, post_hit, tb_step);
endinterface : ccp_tmr_if
`default_nettype wire

// ===== hdl/ccp_tmr.sv
// Purpose: 8-bit period timer with prescaler and postscaler
// Assumes: aclk is the oscillator; one increment per 4 x prescale cycles
// Notes: tb_lo extends the count to the 10-bit time base
`timescale 1ns/1ns
`default_nettype none
module ccp_tmr (
  input wire logic aclk,
  input wire logic aresetn,
  ccp_tmr_if.tmr t
);
  logic [8:0] sub_reg;
  logic [7:0] count_reg;
  logic [3:0] post_reg;
  logic run;
  logic inc;

  function automatic logic [8:0] sub_term(input logic [2:0] ps);
    sub_term = 9'((10'h004 << ps) - 10'h001);
  endfunction : sub_term

  // ==========================================
  // Prescale and count
  assign run = t.on && !t.sleep;
  assign inc = run && (sub_reg == sub_term(t.ps));
  assign t.wrap = inc && (count_reg == t.period);
  assign t.count = count_reg;
  assign t.tb_lo = 2'(sub_reg >> t.ps);
  // Time base moves on at the next edge
  assign t.tb_step = run && (((sub_reg + 9'h001) >> t.ps) != (sub_reg >> t.ps));
  assign t.post_hit = t.wrap && (post_reg == t.outps);

  always_ff @(posedge aclk) begin
    if (!aresetn || t.cnt_wr) begin
      sub_reg <= 9'h000;
    end else if (run) begin
      sub_reg <= inc ? 9'h000 : sub_reg + 9'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 8'h00;
    end else if (t.cnt_wr) begin
      count_reg <= t.cnt_wdata;
    end else if (inc) begin
      count_reg <= t.wrap ? 8'h00 : count_reg + 8'h01;
    end
  end

  // Postscaler only paces the flag, never the count
  always_ff @(posedge aclk) begin
    if (!aresetn || !t.on) begin
      post_reg <= 4'h0;
    end else if (t.wrap) begin
      post_reg <= (post_reg == t.outps) ? 4'h0 : post_reg + 4'h1;
    end
  end

  // ==========================================
  // Checks
  property p_wrap_clear;
    @(posedge aclk) disable iff (!aresetn) (t.wrap && !t.cnt_wr) |=> count_reg == 8'h00;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("count not cleared after match");

  property p_sleep_count;
    @(posedge aclk) disable iff (!aresetn) (t.sleep && !t.cnt_wr) |=> $stable(count_reg) && $stable(sub_reg);
  endproperty
  a_sleep_count: assert property (p_sleep_count) else $error("timer moved in sleep");

  property p_phase_step;
    @(posedge aclk) disable iff (!aresetn)
      (run && t.ps == 3'h0 && t.tb_lo != 2'h3 && !t.cnt_wr) ##1 (t.ps == 3'h0)
      |-> t.tb_lo == $past(t.tb_lo) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase bits do not step at 1:1");
endmodule : ccp_tmr
`default_nettype wire

// ===== bench/ccp_load.sv
// Purpose: Load on the PWM pin that measures pulse and period lengths
// Assumes: Pin sampled on aclk, same domain as the unit
// Notes: Lengths in aclk cycles, rise to rise and rise to fall
`timescale 1ns/1ns
`default_nettype none
module ccp_load (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic [15:0] high_len,
  output logic [15:0] per_len,
  output logic [15:0] rises
);
  logic prev_reg;
  logic [15:0] hcnt_reg;
  logic [15:0] pcnt_reg;
  // ==========================================
  // Edge tracking and period length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
      pcnt_reg <= 16'h0000;
      per_len <= 16'h0000;
      rises <= 16'h0000;
    end else begin
      prev_reg <= pin;
      pcnt_reg <= pcnt_reg + 16'h0001;
      if (pin && !prev_reg) begin
        per_len <= pcnt_reg;
        pcnt_reg <= 16'h0001;
        rises <= rises + 16'h0001;
      end
    end
  end
  // ==========================================
  // Pulse length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcnt_reg <= 16'h0000;
      high_len <= 16'h0000;
    end else begin
      hcnt_reg <= pin ? hcnt_reg + 16'h0001 : 16'h0000;
      if (!pin && prev_reg) begin
        high_len <= hcnt_reg;
      end
    end
  end
endmodule : ccp_load
`default_nettype wire

// ===== bench/ccp_pwm_bench.sv
// Purpose: Self-checking bench of the PWM unit
// Assumes: 125 MHz aclk, bench acts as AXI4-Lite master
// Notes: Pin timing is judged through ccp_load
`timescale 1ns/1ns
`default_nettype none
`include "ccp_cfg.svh"
module ccp_pwm_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe, irq;
  logic [31:0] rdata, rdv;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] high_len, per_len, rises, r0;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  always #4 aclk = ~aclk;
  ccp_pwm dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .sleep(sleep), .pwm_output_pin(pin),
    .pwm_pin_oe(oe), .irq(irq));
  ccp_load load (.aclk(aclk), .aresetn(aresetn), .pin(pin), .high_len(high_len), .per_len(per_len),
    .rises(rises));
  // ==========================================
  // Closing and comparison
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      complete_run();
    end
  end
  // ==========================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      k++;
    end while (!tb && k < 100);
    chk(tb, 1'b1);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      rdv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      k++;
    end while (!tr && k < 100);
    chk(tr, 1'b1);
  endtask : rdr
  // ==========================================
  // PWM helpers
  task automatic pwm_on(input logic [7:0] per, input logic [2:0] ps, input logic [7:0] hi,
                        input logic [7:0] lo, input logic fmt);
    wr(`CCP_A_CTL, 8'h00);
    wr(`CCP_A_TPER, per);
    wr(`CCP_A_DLO, lo);
    wr(`CCP_A_DHI, hi);
    wr(`CCP_A_TCLK, 8'h01);
    wr(`CCP_A_TSEL, 8'h55);
    wr(`CCP_A_TCON, {1'b1, ps, 4'h0});
    wr(`CCP_A_CTL, {3'b100, fmt, 4'hC});
  endtask : pwm_on
  task automatic meas(input logic [15:0] eh, input logic [15:0] ep);
    r0 = rises;
    n = 0;
    while (rises - r0 < 3 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    @(negedge aclk);
    chk(high_len, eh);
    chk(per_len, ep);
  endtask : meas
  task automatic hold_check(input logic lv);
    repeat (40) @(posedge aclk);
    r0 = rises;
    repeat (40) @(posedge aclk);
    chk(rises, r0);
    chk(pin, lv);
  endtask : hold_check
  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk({pin, oe, irq}, 3'b000);
    rdr(`CCP_A_CTL);
    chk(rdv, 32'h0000_0000);
    rdr(`CCP_A_TSEL);
    chk(rdv, 32'h0000_0055);
    rdr(`CCP_A_TPER);
    chk(rdv, 32'h0000_00FF);
    rdr(`CCP_A_PDIR);
    chk(rdv, 32'h0000_0001);
    rdr(8'h34);
    chk(rs, `CCP_RESP_ERR);
    chk(rdv, 32'h0000_0000);
    wr(8'h34, 8'h12);
    chk(rs, `CCP_RESP_ERR);
  endtask : t_reset
  task automatic t_first;
    pwm_on(8'h03, 3'h0, 8'h00, 8'h08, 1'b0);
    n = 0;
    do begin
      rdr(`CCP_A_IF);
      n++;
    end while (rdv[`CCP_IF_TMR] !== 1'b1 && n < 50);
    chk(rdv[`CCP_IF_TMR], 1'b1);
    wr(`CCP_A_PDIR, 8'h00);
    chk(oe, 1'b1);
    meas(16'h0008, 16'h0010);
  endtask : t_first
  task automatic t_align;
    pwm_on(8'h03, 3'h0, 8'h01, 8'h40, 1'b1);
    meas(16'h0005, 16'h0010);
    pwm_on(8'h7F, 3'h0, 8'hFD, 8'h02, 1'b0);
    meas(16'h0102, 16'h0200);
  endtask : t_align
  task automatic t_scale;
    for (int i = 0; i < 3; i++) begin
      pwm_on(8'h03, i[2:0], 8'h00, 8'h08, 1'b0);
      meas(16'h0008 << i, 16'h0010 << i);
    end
    wr(`CCP_A_TCON, 8'h8F);
    meas(16'h0008, 16'h0010);
  endtask : t_scale
  task automatic t_buffer;
    r0 = rises;
    n = 0;
    while (rises == r0 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    wr(`CCP_A_DLO, 8'h0C);
    n = 0;
    while (pin && n < 100) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
    chk(high_len, 16'h0008);
    meas(16'h000C, 16'h0010);
  endtask : t_buffer
  task automatic t_sleep;
    logic lv;
    logic [31:0] c0;
    @(posedge aclk);
    sleep <= 1'b1;
    repeat (3) @(negedge aclk);
    lv = pin;
    r0 = rises;
    rdr(`CCP_A_TCNT);
    c0 = rdv;
    repeat (40) @(posedge aclk);
    rdr(`CCP_A_TCNT);
    chk(rdv, c0);
    chk(pin, lv);
    chk(rises, r0);
    sleep <= 1'b0;
    meas(16'h000C, 16'h0010);
  endtask : t_sleep
  task automatic t_edges;
    wr(`CCP_A_DLO, 8'h00);
    hold_check(1'b0);
    wr(`CCP_A_DLO, 8'h14);
    hold_check(1'b1);
    wr(`CCP_A_CTL, 8'h00);
    @(negedge aclk);
    chk(pin, 1'b0);
  endtask : t_edges
  task automatic t_irq;
    wr(`CCP_A_IE, 8'h01);
    n = 0;
    while (!irq && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(irq, 1'b1);
    rdr(`CCP_A_IF);
    chk(rdv[`CCP_IF_TMR], 1'b1);
    wr(`CCP_A_IE, 8'h00);
    chk(irq, 1'b0);
    wr(`CCP_A_TCON, 8'h00);
    rdr(`CCP_A_IF);
    rdr(`CCP_A_IF);
    chk(rdv, 32'h0000_0000);
    wr(`CCP_A_IE, 8'h01);
    chk(irq, 1'b0);
  endtask : t_irq
  task automatic t_rerun;
    pwm_on(8'h03, 3'h0, 8'h00, 8'h08, 1'b0);
    wr(`CCP_A_PDIR, 8'h00);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({pin, oe, irq}, 3'b000);
    rdr(`CCP_A_DLO);
    chk(rdv, 32'h0000_0000);
    rdr(`CCP_A_TPER);
    chk(rdv, 32'h0000_00FF);
  endtask : t_rerun
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_first();
    t_align();
    t_scale();
    wr(`CCP_A_TCON, 8'h80);
    t_buffer();
    t_sleep();
    t_edges();
    t_irq();
    t_rerun();
    complete_run();
  end
endmodule : ccp_pwm_bench
`default_nettype wire
